// ==== pkg/srs_defs.vh ====
// srs_defs.vh: constants for the scratch readout store
// assumes inclusion by bare name from hdl files; definitions only
`ifndef SRS_DEFS_VH
`define SRS_DEFS_VH

// ****************************************
// mode register three fields
// ****************************************
`define SRS_FMT_HI 12
`define SRS_FMT_LO 11
`define SRS_ACC_BIT 2
`define SRS_PAGE_HI 1
`define SRS_PAGE_LO 0
`define SRS_FMT_SERIAL 2'h0
`define SRS_FMT_PARALLEL 2'h1
`define SRS_FMT_STAGGER 2'h2
`define SRS_FMT_RSVD 2'h3

// ****************************************
// page 0 defaults
// ****************************************
`define SRS_P0_LOC0 8'h55
`define SRS_P0_LOC1 8'h33
`define SRS_P0_LOC2 8'h0f
`define SRS_P0_LOC3 8'h00

// ****************************************
// refresh-rate codes and vendor page
// ****************************************
`define SRS_REF_SUB1X 2'h0
`define SRS_REF_1X 2'h1
`define SRS_REF_2X 2'h2
`define SRS_VENDOR_FILL 8'h00

// ****************************************
// burst timing
// ****************************************
`define SRS_UI_COUNT 4'h8
`define SRS_LAST_UI 3'h7
`define SRS_STALL_LIMIT 8'hff

`endif

// ==== hdl/srs_readout.v ====
// srs_readout.v: scratch readout store of a dram, four pages of four bytes
// assumes command decode upstream; strobes are single-cycle on i_clk,
// the link clock is a pin sampled and edge-detected here
//
// Operation
// - format field 00 serial, 01 parallel, 10 staggered
// - access bit redirects reads and writes here
// - page field selects one of four pages
// - address bits A7..A0 write; serial bit7 first out, bit3 on a half burst
// - page 0 writable with fixed defaults
// - page 1 loc3: crc, parity, parity latency
// - page 2 loc1: reference range, value, gear-down
// - page 2 loc2/3: latency, termination settings
// - refresh-rate field codes, 11 reserved
// - page 3 vendor, mostly don't-care
// - page 0 writes persist until reinit
// - serial burst same on every lane
`timescale 1ns/1ps
`include "srs_defs.vh"

module srs_readout (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // link clock pin and reinit
  input wire i_link_clk,
  input wire i_reinit,
  // mode register set
  input wire i_mrs_three,
  input wire [17:0] i_mrs_addr,
  // access commands
  input wire i_rd,
  input wire i_wr,
  input wire [1:0] i_ba,
  input wire [7:0] i_wr_addr,
  input wire i_burst_half,
  // error log capture
  input wire i_err_capture,
  input wire [17:0] i_err_addr,
  input wire [1:0] i_err_bg,
  input wire [1:0] i_err_ba,
  input wire i_err_act_n,
  input wire i_err_par,
  input wire i_crc_err,
  input wire i_par_err,
  input wire i_err_clear,
  // mirrored settings
  input wire [2:0] i_mode_reg_five_lo,
  input wire [2:0] i_mode_reg_five_park,
  input wire [6:0] i_mode_reg_six,
  input wire [2:0] i_mode_reg_one_nom,
  input wire [6:0] i_mode_reg_zero,
  input wire i_gear_down,
  input wire i_hard_row_repair_support,
  input wire i_soft_row_repair_support,
  input wire [1:0] i_refresh_rate,
  input wire [1:0] i_temp_stat,
  // status
  output reg o_access_en,
  output reg [1:0] o_page,
  output reg [1:0] o_format,
  output reg o_fmt_reserved,
  // data lanes
  output reg [7:0] o_dq,
  output reg o_dq_oe_n,
  output reg o_burst_done
);

  // ****************************************
  // helpers
  // ****************************************
  function [7:0] bit_reverse;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        bit_reverse[k] = v[7 - k];
      end
    end
  endfunction

  // one unit interval of a byte; the top bit goes out first
  function ui_bit;
    input [7:0] v;
    input [2:0] ui;
    begin
      ui_bit = v[3'h7 - ui];
    end
  endfunction

  // pages 1-3 and the reserved code read out serially
  function [1:0] eff_format;
    input [1:0] page;
    input [1:0] fmt;
    begin
      if (page != 2'h0 || fmt == `SRS_FMT_RSVD) begin
        eff_format = `SRS_FMT_SERIAL;
      end else begin
        eff_format = fmt;
      end
    end
  endfunction

  function [7:0] lane_pattern;
    input [1:0] fmt;
    input [7:0] v;
    input [2:0] ui;
    input [7:0] stag;
    begin
      case (fmt)
        `SRS_FMT_PARALLEL: lane_pattern = v;
        `SRS_FMT_STAGGER: lane_pattern = {8{ui_bit(stag, ui)}};
        default: lane_pattern = {8{ui_bit(v, ui)}};
      endcase
    end
  endfunction

  // ****************************************
  // link clock sync and edge find
  // ****************************************
  reg link_s1;
  reg link_s2;
  reg link_prev;
  wire link_rise;
  // two stages only; the first is read by the second alone
  always @(posedge i_clk) begin
    link_s1 <= i_link_clk;
    link_s2 <= link_s1;
    link_prev <= link_s2;
  end
  assign link_rise = link_s2 & ~link_prev;

  // ****************************************
  // mode register three
  // ****************************************
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_access_en <= 1'b0;
      o_page <= 2'h0;
      o_format <= `SRS_FMT_SERIAL;
      o_fmt_reserved <= 1'b0;
    end else if (i_mrs_three) begin
      o_access_en <= i_mrs_addr[`SRS_ACC_BIT];
      o_page <= i_mrs_addr[`SRS_PAGE_HI:`SRS_PAGE_LO];
      o_format <= i_mrs_addr[`SRS_FMT_HI:`SRS_FMT_LO];
      // reserved code is flagged and read out as serial
      o_fmt_reserved <= (i_mrs_addr[`SRS_FMT_HI:`SRS_FMT_LO] == `SRS_FMT_RSVD);
    end
  end

  // ****************************************
  // page 0 patterns
  // ****************************************
  reg [7:0] page0 [0:3];
  always @(posedge i_clk) begin
    if (i_reset || i_reinit) begin
      page0[0] <= `SRS_P0_LOC0;
      page0[1] <= `SRS_P0_LOC1;
      page0[2] <= `SRS_P0_LOC2;
      page0[3] <= `SRS_P0_LOC3;
    end else if (o_access_en && i_wr && o_page == 2'h0) begin
      page0[i_ba] <= i_wr_addr;
    end
  end

  // ****************************************
  // page 1 error log
  // ****************************************
  reg [7:0] log0;
  reg [7:0] log1;
  reg [7:0] log2;
  reg crc_flag;
  reg par_flag;
  always @(posedge i_clk) begin
    if (i_reset) begin
      log0 <= 8'h00;
      log1 <= 8'h00;
      log2 <= 8'h00;
    end else if (i_err_capture) begin
      log0 <= i_err_addr[7:0];
      log1 <= i_err_addr[15:8];
      log2 <= {i_err_par, i_err_act_n, i_err_bg, i_err_ba, i_err_addr[17], i_err_addr[16]};
    end
  end
  // set wins over clear
  always @(posedge i_clk) begin
    if (i_reset) begin
      crc_flag <= 1'b0;
      par_flag <= 1'b0;
    end else begin
      crc_flag <= i_crc_err | (crc_flag & ~i_err_clear);
      par_flag <= i_par_err | (par_flag & ~i_err_clear);
    end
  end

  // ****************************************
  // location select
  // ****************************************
  reg [7:0] sel;
  always @* begin
    sel = 8'h00;
    case (o_page)
      2'h0: sel = page0[i_ba];
      2'h1: begin
        case (i_ba)
          2'h0: sel = log0;
          2'h1: sel = log1;
          2'h2: sel = log2;
          default: sel = {crc_flag, par_flag, i_mode_reg_five_lo, 3'h0};
        endcase
      end
      2'h2: begin
        case (i_ba)
          2'h0: sel = {i_hard_row_repair_support, i_soft_row_repair_support, 6'h00};
          2'h1: sel = {i_mode_reg_six[6], i_mode_reg_six[5:0], i_gear_down};
          2'h2: sel = {i_mode_reg_zero[6:4], i_mode_reg_zero[2], i_mode_reg_zero[3], 3'h0};
          default: sel = {i_mode_reg_one_nom, i_mode_reg_five_park, i_temp_stat};
        endcase
      end
      default: begin
        // vendor page: only the refresh-rate field, bits 4:3 of loc3, defined
        if (i_ba == 2'h3) begin
          sel = {3'h0, i_refresh_rate, 3'h0};
        end else begin
          sel = `SRS_VENDOR_FILL;
        end
      end
    endcase
  end

  // ****************************************
  // burst engine, one ui per link rising edge
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_BURST = 1'b1;
  reg state;
  reg [7:0] shadow;
  reg [2:0] ui;
  reg [2:0] last_ui;

  // ****************************************
  // stall guard
  // ****************************************
  // a link clock cut mid-burst, or access switched off, would leave the lanes
  // driven for good; the limit trades late release against slow link clocks
  reg [7:0] stall;
  wire burst_abort;
  always @(posedge i_clk) begin
    if (i_reset || state == ST_IDLE || link_rise) begin
      stall <= 8'h00;
    end else if (stall != `SRS_STALL_LIMIT) begin
      stall <= stall + 8'h01;
    end
  end
  assign burst_abort = (stall == `SRS_STALL_LIMIT) || !o_access_en;
  always @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
      shadow <= 8'h00;
      ui <= 3'h0;
      last_ui <= 3'h0;
      o_dq <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_burst_done <= 1'b0;
    end else begin
      o_burst_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_dq_oe_n <= 1'b1;
          if (o_access_en && i_rd) begin
            // parallel always reads location 0 data
            shadow <= (eff_format(o_page, o_format) == `SRS_FMT_PARALLEL) ? page0[0] : sel;
            ui <= i_burst_half ? 3'h4 : 3'h0;
            last_ui <= i_burst_half ? `SRS_LAST_UI : (`SRS_LAST_UI);
            state <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (burst_abort) begin
            // cut frame: lanes released, no done pulse
            state <= ST_IDLE;
            o_dq_oe_n <= 1'b1;
          end else if (link_rise) begin
            o_dq_oe_n <= 1'b0;
            // only page 0 honours non-serial formats
            o_dq <= lane_pattern(eff_format(o_page, o_format),
              shadow, ui, bit_reverse(shadow));
            ui <= ui + 3'h1;
            if (ui == last_ui) begin
              state <= ST_IDLE;
              o_burst_done <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // srs_readout

// ==== test/srs_readout_props.sv ====
// srs_readout_props.sv: port checker for the readout store
// assumes one clock domain, bound onto srs_readout
`timescale 1ns/1ps
module srs_readout_props (
  input wire i_clk,
  input wire i_reset,
  input wire i_mrs_three,
  input wire [17:0] i_mrs_addr,
  input wire i_rd,
  input wire o_access_en,
  input wire [1:0] o_page,
  input wire [1:0] o_format,
  input wire o_fmt_reserved,
  input wire [7:0] o_dq,
  input wire o_dq_oe_n,
  input wire o_burst_done
);
  // ****
  // mode and burst checks
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence rd_take; o_access_en && i_rd && o_dq_oe_n; endsequence
  sequence burst_end; o_burst_done ##[1:2] o_dq_oe_n; endsequence
  acc_bit_a: assert property (i_mrs_three |=> o_access_en == $past(i_mrs_addr[2])) else $error("access bit");
  page_sel_a: assert property (i_mrs_three |=> o_page == $past(i_mrs_addr[1:0])) else $error("page");
  fmt_sel_a: assert property (i_mrs_three |=> o_format == $past(i_mrs_addr[12:11])) else $error("format");
  fmt_flag_a: assert property (o_fmt_reserved == (o_format == 2'h3)) else $error("reserved flag");
  off_quiet_a: assert property (!o_access_en && o_dq_oe_n |=> o_dq_oe_n) else $error("lanes driven");
  rd_answer_a: assert property (rd_take |-> ##[1:40] !o_dq_oe_n ##[60:300] o_burst_done) else $error("no burst");
  burst_close_a: assert property (o_burst_done |-> burst_end) else $error("no release");
  lane_copy_a: assert property (!o_dq_oe_n && (o_format[0] == o_format[1] || o_page != 2'h0) |-> o_dq[0] ?
    o_dq == 8'hff : o_dq == 8'h00) else $error("lanes differ");
endmodule // srs_readout_props

bind srs_readout srs_readout_props chk (.*);

// ==== test/srs_ctrl_model.sv ====
// srs_ctrl_model.sv: controller side, paces the link clock
// assumes the bench raises i_run for the length of each read
`timescale 1ns/1ps
module srs_ctrl_model (
  input wire i_run,
  output reg o_link_clk
);
  initial o_link_clk = 1'b0;
  // stands still between reads; only allowed commands are sent then
  always begin
    wait (i_run);
    #31.3 o_link_clk = 1'b1;
    #62.5 o_link_clk = 1'b0;
    #31.2;
  end
endmodule // srs_ctrl_model

// ==== test/srs_readout_tb.sv ====
// srs_readout_tb.sv: self-checking bench for the readout store
// assumes srs_ctrl_model runs the link clock only during reads
`timescale 1ns/1ps
module srs_readout_tb;
  localparam [31:0] DFLT = 32'h000f3355;
  reg i_clk = 1'b0, i_reset = 1'b1, run = 1'b0, i_rd = 1'b0, i_burst_half = 1'b0;
  reg i_mrs_three = 1'b0, i_wr = 1'b0, i_reinit = 1'b0, i_err_capture = 1'b0, i_crc_err = 1'b0;
  reg [17:0] i_mrs_addr = 18'h0;
  reg [1:0] i_ba = 2'h0;
  reg [7:0] i_wr_addr = 8'h0;
  reg [63:0] r = 64'h0;
  reg [31:0] seed = 32'h26d95e47;
  wire i_link_clk, o_dq_oe_n, o_burst_done;
  wire [7:0] o_dq;
  integer err_count = 0, tests_run = 0, cyc = 0, b;
  logic [15:0] q[$];
  logic [15:0] e;
  always #2.5 i_clk = ~i_clk;
  srs_ctrl_model PM (.i_run(run), .o_link_clk(i_link_clk));
  srs_readout DUT (.i_clk(i_clk), .i_reset(i_reset), .i_link_clk(i_link_clk), .i_reinit(i_reinit),
    .i_mrs_three(i_mrs_three), .i_mrs_addr(i_mrs_addr), .i_rd(i_rd), .i_wr(i_wr), .i_ba(i_ba),
    .i_wr_addr(i_wr_addr), .i_burst_half(i_burst_half), .i_err_capture(i_err_capture), .i_crc_err(i_crc_err),
    .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_burst_done(o_burst_done),
    .i_err_addr(r[17:0]), .i_err_bg(r[19:18]), .i_err_ba(r[21:20]),
    .i_err_act_n(r[22]), .i_err_par(r[23]), .i_par_err(r[54]), .i_err_clear(1'b0), .i_mode_reg_five_lo(r[26:24]),
    .i_mode_reg_five_park(r[29:27]), .i_mode_reg_six(r[36:30]), .i_mode_reg_one_nom(r[39:37]),
    .i_mode_reg_zero(r[46:40]), .i_gear_down(r[47]), .i_hard_row_repair_support(r[48]),
    .i_soft_row_repair_support(r[49]), .i_refresh_rate(r[51:50]), .i_temp_stat(r[53:52]), .o_access_en(),
    .o_page(), .o_format(), .o_fmt_reserved());
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [7:0] got, input [7:0] want);
    tests_run = tests_run + 1;
    if (got !== want) begin
      err_count = err_count + 1;
      $display("[ERR] %0t lanes %h want %h", $time, got, want);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one-cycle strobe: {mode write, data write, reinit, capture, crc}
  task strobe(input [4:0] s, input [17:0] a);
    @(posedge i_clk);
    {i_mrs_three, i_wr, i_reinit, i_err_capture, i_crc_err} <= s;
    i_mrs_addr <= a;
    i_ba <= a[17:16];
    i_wr_addr <= a[7:0];
    @(posedge i_clk);
    {i_mrs_three, i_wr, i_reinit, i_err_capture, i_crc_err} <= 5'h0;
  endtask
  // fm 0 serial, 1 whole byte, 2 reversed; m hides don't-care bits
  task rdb(input [1:0] l, input [1:0] fm, input [7:0] v, input [7:0] m = 8'hff, input h = 1'b0);
    integer n, k;
    for (n = h ? 4 : 0; n < 8; n = n + 1) begin
      k = (fm == 2'h2) ? n : 7 - n;
      q.push_back(fm == 2'h1 ? {m, v} : {{8{m[k]}}, {8{v[k]}}});
    end
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_burst_half <= h;
    i_ba <= l;
    run <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    for (k = 0; k < 400 && o_burst_done !== 1'b1; k = k + 1) @(posedge i_clk);
    run <= 1'b0;
    repeat (30) @(posedge i_clk);
    if (k == 400 || q.size() != 0) chk(8'h00, 8'h01);
    q.delete();
    $display("read of location %0d ends", l);
  endtask
  // sampled well after the synchroniser has landed the unit
  always @(posedge i_link_clk) if (q.size() != 0) begin
    #24;
    e = q.pop_front();
    chk(o_dq & e[15:8], e[7:0] & e[15:8]);
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    seed = xs(seed);
    r[31:0] <= seed;
    seed = xs(seed);
    r[63:32] <= seed;
    strobe(5'h10, 18'h4);
    for (b = 0; b < 4; b = b + 1) rdb(b[1:0], 2'h0, DFLT[8 * b +: 8]);
    for (b = 1; b < 4; b = b + 1) begin
      strobe(5'h10, {5'h0, b[1:0], 11'h4});
      rdb(2'h0, (b == 3) ? 2'h0 : b[1:0], 8'h55);
    end
    strobe(5'h10, 18'h4);
    strobe(5'h08, {2'h3, 8'h0, seed[7:0]});
    rdb(2'h3, 2'h0, seed[7:0]);
    strobe(5'h10, 18'h0);
    strobe(5'h08, {2'h2, 8'h0, ~seed[7:0]});
    strobe(5'h10, 18'h4);
    rdb(2'h2, 2'h0, 8'h0f);
    strobe(5'h04, 18'h0);
    rdb(2'h3, 2'h0, 8'h00);
    rdb(2'h1, 2'h0, 8'h33, 8'hff, 1'b1);
    strobe(5'h13, 18'h5);
    rdb(2'h0, 2'h0, r[7:0]);
    rdb(2'h1, 2'h0, r[15:8]);
    rdb(2'h2, 2'h0, {r[23:22], r[19:18], r[21:20], r[17:16]});
    rdb(2'h3, 2'h0, {1'b1, r[54], r[26:24], 3'h0}, 8'hf8);
    strobe(5'h10, 18'h6);
    rdb(2'h1, 2'h0, {r[36:30], r[47]});
    rdb(2'h0, 2'h0, {r[48], r[49], 6'h00}, 8'hc0);
    rdb(2'h2, 2'h0, {r[46:44], r[42], r[43], 3'h0}, 8'hf8);
    rdb(2'h3, 2'h0, {r[39:37], r[29:27], 2'h0}, 8'hfc);
    strobe(5'h10, 18'h7);
    rdb(2'h3, 2'h0, {3'h0, r[51:50], 3'h0}, 8'h18);
    close_out;
  end
endmodule // srs_readout_tb
